// file: rtl/oddss_pkg.sv
package oddss_pkg;

	// ==========================================================
	// Sizes
	localparam int GROUPS      = 6;
	localparam int STATUS_PINS = 5;
	localparam int INPUTS      = 2;
	localparam int DLY_W       = 10;
	localparam int N2_W        = 18;
	localparam int LOS_W       = 16;
	localparam int SEL_W       = 5;

	// ==========================================================
	// Delay figures, in distribution clock cycles
	localparam logic [DLY_W-1:0] DDLY_MIN   = 10'h005;
	localparam logic [DLY_W-1:0] DDLY_MAX   = 10'h20a;
	localparam logic [DLY_W-1:0] SYNC_LAT   = 10'h006;
	localparam logic [DLY_W-1:0] CNT_WHOLE  = 10'h001;
	localparam logic [DLY_W-1:0] CNT_EARLY  = 10'h002;

	// ==========================================================
	// Calibration timing
	localparam int CLK_PERIOD_NS = 40;
	localparam int CAL_TIME_NS   = 10000;
	localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CAL_W         = 9;
	localparam logic [CAL_W-1:0] CAL_LAST = CAL_W'(CAL_CYCLES - 1);

	// ==========================================================
	// Types
	typedef struct packed {
		logic ld1;
		logic ld2;
		logic holdover;
		logic dac_locked;
		logic dac_rail;
		logic dac_low;
		logic dac_high;
	} oddss_flags_type;

	typedef struct packed {
		logic [DLY_W-1:0] whole;
		logic             half;
		logic             exclude;
	} oddss_delay_cfg_type;

	typedef enum logic [SEL_W-1:0] {
		SRC_LOW       = 5'h00,
		SRC_LD1       = 5'h01,
		SRC_LD2       = 5'h02,
		SRC_LD_BOTH   = 5'h03,
		SRC_HOLDOVER  = 5'h04,
		SRC_DAC_LOCK  = 5'h05,
		SRC_DAC_RAIL  = 5'h06,
		SRC_DAC_LOW   = 5'h07,
		SRC_DAC_HIGH  = 5'h08,
		SRC_R1_DIV    = 5'h09,
		SRC_N1_DIV    = 5'h0a,
		SRC_R2_DIV    = 5'h0b,
		SRC_N2_DIV    = 5'h0c,
		SRC_R1_HALF   = 5'h0d,
		SRC_N1_HALF   = 5'h0e,
		SRC_R2_HALF   = 5'h0f,
		SRC_N2_HALF   = 5'h10,
		SRC_LOS0      = 5'h11,
		SRC_LOS1      = 5'h12,
		SRC_SEL0      = 5'h13,
		SRC_SEL1      = 5'h14,
		SRC_READBACK  = 5'h15
	} oddss_src_type;

	typedef enum logic {
		CAL_IDLE = 1'b0,
		CAL_RUN  = 1'b1
	} oddss_cal_state_type;

endpackage

// file: rtl/oddss_delay_group.sv
`timescale 1ns/1ns
module oddss_delay_group
	import oddss_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_i,
	input  wire logic                arst_n_i,
	// Configuration and synchronisation
	input  wire oddss_delay_cfg_type cfg_i,
	input  wire logic                sync_hold_i,
	input  wire logic                sync_release_i,
	// Result
	output logic                     group_o,
	output logic [DLY_W-1:0]         loaded_delay_o
);

	logic [DLY_W-1:0] loaded;
	logic [DLY_W-1:0] cnt;
	logic             whole_gate;
	logic             early_gate;
	logic             half_gate;
	logic [DLY_W:0]   since_release;
	logic             take;
	logic [DLY_W-1:0] clamped;

	assign take = !cfg_i.exclude;

	// ==========================================================
	// Delay captured at the sync event
	always_comb
	begin
		clamped = cfg_i.whole;
		if (clamped < DDLY_MIN)
			clamped = DDLY_MIN;
		else if (clamped > DDLY_MAX)
			clamped = DDLY_MAX;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			loaded <= DDLY_MIN;
		else if (sync_hold_i && take)
			loaded <= clamped;
	end

	// ==========================================================
	// Countdown on the distribution clock
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			cnt <= '0;
		else if (take && sync_hold_i)
			cnt <= '0;
		else if (take && sync_release_i)
			cnt <= SYNC_LAT + loaded;
		else if (cnt != '0)
			cnt <= cnt - CNT_WHOLE;
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			whole_gate <= 1'b1;
			early_gate <= 1'b1;
		end
		else if (take && (sync_hold_i || sync_release_i))
		begin
			whole_gate <= 1'b0;
			early_gate <= 1'b0;
		end
		else
		begin
			if (cnt == CNT_WHOLE)
				whole_gate <= 1'b1;
			if (cnt == CNT_EARLY)
				early_gate <= 1'b1;
		end
	end

	// Half step: launch from the falling edge, half a cycle ahead
	always_ff @(negedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			half_gate <= 1'b1;
		else
			half_gate <= early_gate;
	end

	// Half-step bit acts at once, no sync needed
	assign group_o        = cfg_i.half ? half_gate : whole_gate;
	assign loaded_delay_o = loaded;

	// ==========================================================
	// Checks
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			since_release <= '0;
		else if (take && sync_release_i)
			since_release <= '0;
		else if (since_release != {(DLY_W+1){1'b1}})
			since_release <= since_release + 1'b1;
	end

	property p_whole_rise;
		@(posedge clk_i) disable iff (!arst_n_i)
		$rose(whole_gate) |-> (since_release == {1'b0, SYNC_LAT + loaded});
	endproperty
	a_whole_rise: assert property (p_whole_rise)
		else $error("whole-cycle launch at wrong cycle");

	property p_held_low;
		@(posedge clk_i) disable iff (!arst_n_i)
		(sync_hold_i && take) |=> !whole_gate && !early_gate;
	endproperty
	a_held_low: assert property (p_held_low)
		else $error("included group not held low during sync");

	property p_excluded_keep;
		@(posedge clk_i) disable iff (!arst_n_i)
		cfg_i.exclude |=> $stable(loaded);
	endproperty
	a_excluded_keep: assert property (p_excluded_keep)
		else $error("excluded group took a new delay");

	property p_half_lead;
		@(posedge clk_i) disable iff (!arst_n_i)
		($rose(early_gate) && !sync_hold_i && !sync_release_i) |-> !whole_gate ##1 whole_gate;
	endproperty
	a_half_lead: assert property (p_half_lead)
		else $error("half-step launch not one half cycle early");

	property p_delay_range;
		@(posedge clk_i) disable iff (!arst_n_i)
		(loaded >= DDLY_MIN) && (loaded <= DDLY_MAX);
	endproperty
	a_delay_range: assert property (p_delay_range)
		else $error("loaded delay outside range");

endmodule

// file: rtl/oddss_status_delay.sv
`timescale 1ns/1ns
module oddss_status_delay
	import oddss_pkg::*;
(
	// Clock and reset
	input  wire logic                                 clk_i,
	input  wire logic                                 arst_n_i,
	// Status sources
	input  wire oddss_flags_type                      flags_i,
	input  wire logic                                 loop1_reference_divider_i,
	input  wire logic                                 loop1_feedback_divider_i,
	input  wire logic                                 loop2_reference_divider_i,
	input  wire logic                                 loop2_feedback_divider_i,
	input  wire logic                                 readback_data_i,
	input  wire logic                                 active_input_i,
	input  wire logic [STATUS_PINS-1:0][SEL_W-1:0]    status_select_i,
	output logic      [STATUS_PINS-1:0]               status_o,
	// Loss of signal
	input  wire logic [INPUTS-1:0]                    clock_input_i,
	input  wire logic                                 signal_loss_detect_enable_i,
	input  wire logic [LOS_W-1:0]                     signal_loss_timeout_threshold_i,
	output logic      [INPUTS-1:0]                    input_signal_lost_flag_o,
	// Oscillator calibration
	input  wire logic                                 loop2_feedback_write_i,
	input  wire logic [N2_W-1:0]                      loop2_feedback_divide_value_i,
	input  wire logic [N2_W-1:0]                      loop2_calibration_divide_value_i,
	output logic                                      cal_busy_o,
	output logic      [N2_W-1:0]                      loop2_feedback_active_o,
	// Distribution step
	input  wire logic                                 oscillator_divider_bypass_i,
	input  wire logic [3:0]                           oscillator_divide_ratio_i,
	output logic      [3:0]                           delay_step_ratio_o,
	// Output group delay
	input  wire logic                                 sync_n_i,
	input  wire oddss_delay_cfg_type [GROUPS-1:0]     group_cfg_i,
	output logic      [GROUPS-1:0]                    group_o,
	output logic      [GROUPS-1:0][DLY_W-1:0]         loaded_delay_o
);

	// ==========================================================
	// Divider outputs, divide-by-two versions
	logic [3:0] div_pulse;
	logic [3:0] div_half;

	assign div_pulse = {loop2_feedback_divider_i, loop2_reference_divider_i,
		loop1_feedback_divider_i, loop1_reference_divider_i};

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			div_half <= '0;
		else
			div_half <= div_half ^ div_pulse;
	end

	property p_half_hold;
		@(posedge clk_i) disable iff (!arst_n_i)
		!div_pulse[3] |=> $stable(div_half[3]);
	endproperty
	a_half_hold: assert property (p_half_hold)
		else $error("half-rate output moved without a comparison");

	// ==========================================================
	// Loss of signal per clock input
	logic [INPUTS-1:0][2:0]       in_sync;
	logic [INPUTS-1:0]            in_level;
	logic [INPUTS-1:0][LOS_W-1:0] quiet_cnt;

	genvar gi;
	generate
		for (gi = 0; gi < INPUTS; gi++)
		begin : g_los
			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
				begin
					in_sync[gi]  <= '0;
					in_level[gi] <= 1'b0;
				end
				else
				begin
					in_sync[gi] <= {in_sync[gi][1:0], clock_input_i[gi]};
					if (in_sync[gi][1] == in_sync[gi][2])
						in_level[gi] <= in_sync[gi][2];
				end
			end

			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					quiet_cnt[gi] <= '0;
				else if ((in_sync[gi][1] == in_sync[gi][2]) && (in_sync[gi][2] != in_level[gi]))
					quiet_cnt[gi] <= '0;
				else if (quiet_cnt[gi] != {LOS_W{1'b1}})
					quiet_cnt[gi] <= quiet_cnt[gi] + 1'b1;
			end

			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					input_signal_lost_flag_o[gi] <= 1'b0;
				else
					input_signal_lost_flag_o[gi] <= signal_loss_detect_enable_i
						&& (quiet_cnt[gi] >= signal_loss_timeout_threshold_i);
			end

			property p_los_enable;
				@(posedge clk_i) disable iff (!arst_n_i)
				!signal_loss_detect_enable_i |=> !input_signal_lost_flag_o[gi];
			endproperty
			a_los_enable: assert property (p_los_enable)
				else $error("loss flag set while detection disabled");
		end
	endgenerate

	// ==========================================================
	// Status pin source selection
	logic [INPUTS-1:0] in_selected;

	assign in_selected = {active_input_i, !active_input_i};

	generate
		for (gi = 0; gi < STATUS_PINS; gi++)
		begin : g_pin
			logic next_status;

			always_comb
			begin
				unique case (oddss_src_type'(status_select_i[gi]))
					SRC_LD1:      next_status = flags_i.ld1;
					SRC_LD2:      next_status = flags_i.ld2;
					SRC_LD_BOTH:  next_status = flags_i.ld1 && flags_i.ld2;
					SRC_HOLDOVER: next_status = flags_i.holdover;
					SRC_DAC_LOCK: next_status = flags_i.dac_locked;
					SRC_DAC_RAIL: next_status = flags_i.dac_rail;
					SRC_DAC_LOW:  next_status = flags_i.dac_low;
					SRC_DAC_HIGH: next_status = flags_i.dac_high;
					SRC_R1_DIV:   next_status = div_pulse[0];
					SRC_N1_DIV:   next_status = div_pulse[1];
					SRC_R2_DIV:   next_status = div_pulse[2];
					SRC_N2_DIV:   next_status = div_pulse[3];
					SRC_R1_HALF:  next_status = div_half[0];
					SRC_N1_HALF:  next_status = div_half[1];
					SRC_R2_HALF:  next_status = div_half[2];
					SRC_N2_HALF:  next_status = div_half[3];
					SRC_LOS0:     next_status = input_signal_lost_flag_o[0];
					SRC_LOS1:     next_status = input_signal_lost_flag_o[1];
					SRC_SEL0:     next_status = in_selected[0];
					SRC_SEL1:     next_status = in_selected[1];
					SRC_READBACK: next_status = readback_data_i;
					default:      next_status = 1'b0;
				endcase
			end

			always_ff @(posedge clk_i or negedge arst_n_i)
			begin
				if (!arst_n_i)
					status_o[gi] <= 1'b0;
				else
					status_o[gi] <= next_status;
			end

			property p_pin_pulse;
				@(posedge clk_i) disable iff (!arst_n_i)
				(status_select_i[gi] == SRC_N2_DIV) |=> (status_o[gi] == $past(loop2_feedback_divider_i));
			endproperty
			a_pin_pulse: assert property (p_pin_pulse)
				else $error("divider pulse not shown on status pin");

			property p_pin_sel;
				@(posedge clk_i) disable iff (!arst_n_i)
				(status_select_i[gi] == SRC_SEL1 && active_input_i) |=> status_o[gi];
			endproperty
			a_pin_sel: assert property (p_pin_sel)
				else $error("selected-input indication missing");
		end
	endgenerate

	// ==========================================================
	// Oscillator calibration
	oddss_cal_state_type cal_state;
	logic [CAL_W-1:0]    cal_cnt;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			cal_state <= CAL_IDLE;
			cal_cnt   <= '0;
		end
		else if (loop2_feedback_write_i)
		begin
			cal_state <= CAL_RUN;
			cal_cnt   <= '0;
		end
		else
		begin
			unique case (cal_state)
				CAL_IDLE: cal_cnt <= '0;
				CAL_RUN:
				begin
					cal_cnt <= cal_cnt + 1'b1;
					if (cal_cnt == CAL_LAST)
						cal_state <= CAL_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			loop2_feedback_active_o <= '0;
		else if (cal_state == CAL_RUN || loop2_feedback_write_i)
			loop2_feedback_active_o <= loop2_calibration_divide_value_i;
		else
			loop2_feedback_active_o <= loop2_feedback_divide_value_i;
	end

	assign cal_busy_o = (cal_state == CAL_RUN);

	property p_cal_start;
		@(posedge clk_i) disable iff (!arst_n_i)
		loop2_feedback_write_i |=> cal_busy_o [*8];
	endproperty
	a_cal_start: assert property (p_cal_start)
		else $error("write did not start calibration");

	property p_cal_value;
		@(posedge clk_i) disable iff (!arst_n_i)
		(cal_busy_o && $stable(loop2_calibration_divide_value_i)) |=>
			(loop2_feedback_active_o == $past(loop2_calibration_divide_value_i));
	endproperty
	a_cal_value: assert property (p_cal_value)
		else $error("calibration divide value not in use");

	// ==========================================================
	// Distribution step size
	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
			delay_step_ratio_o <= 4'h1;
		else
			delay_step_ratio_o <= oscillator_divider_bypass_i ? 4'h1 : oscillator_divide_ratio_i;
	end

	// ==========================================================
	// Sync input and output groups
	logic [2:0] sync_sync;
	logic       sync_hold;
	logic       sync_release;

	always_ff @(posedge clk_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			sync_sync <= 3'h7;
			sync_hold <= 1'b0;
		end
		else
		begin
			sync_sync <= {sync_sync[1:0], sync_n_i};
			if (sync_sync[1] == sync_sync[2])
				sync_hold <= !sync_sync[2];
		end
	end

	assign sync_release = sync_hold && (sync_sync[1] == sync_sync[2]) && sync_sync[2];

	// Relative delay falls out of independent per-group counts
	generate
		for (gi = 0; gi < GROUPS; gi++)
		begin : g_grp
			oddss_delay_group u_grp (
				.clk_i          (clk_i),
				.arst_n_i       (arst_n_i),
				.cfg_i          (group_cfg_i[gi]),
				.sync_hold_i    (sync_hold && !sync_release),
				.sync_release_i (sync_release),
				.group_o        (group_o[gi]),
				.loaded_delay_o (loaded_delay_o[gi])
			);
		end
	endgenerate

endmodule

// file: bench/oddss_far_end.sv
`timescale 1ns/1ns
module oddss_far_end
	import oddss_pkg::*;
(
	// Clock and control from the bench
	input  wire logic              clk_i,
	input  wire logic [INPUTS-1:0] run_i,
	input  wire logic [3:0]        pulse_en_i,
	input  wire logic [7:0]        pulse_period_i,
	// Pins seen by the block
	output logic      [INPUTS-1:0] clock_input_o,
	output logic      [3:0]        divider_pulse_o
);
	// ==========================================================
	// Reference inputs on unrelated timing; a stopped input freezes
	int count = 0;

	initial clock_input_o = '0;
	initial divider_pulse_o = '0;
	always #53 if (run_i[0]) clock_input_o[0] = ~clock_input_o[0];
	always #67 if (run_i[1]) clock_input_o[1] = ~clock_input_o[1];

	// ==========================================================
	// Divider outputs: one-cycle pulse once per comparison period
	always @(posedge clk_i)
	begin
		#1;
		count = (count + 1 >= pulse_period_i) ? 0 : count + 1;
		divider_pulse_o = (count == 0) ? pulse_en_i : 4'h0;
	end
endmodule

// file: bench/output_digital_delay_and_status_select_test.sv
`timescale 1ns/1ns
module output_digital_delay_and_status_select_test
	import oddss_pkg::*;
	;
	logic                             clk_i = 1'b0;
	logic                             arst_n_i = 1'b0;
	oddss_flags_type                  flags = '0;
	logic                             rb = 1'b0;
	logic                             act = 1'b0;
	logic [STATUS_PINS-1:0][SEL_W-1:0] sel = '0;
	logic [STATUS_PINS-1:0]           status;
	logic [INPUTS-1:0]                run = '0;
	logic [INPUTS-1:0]                cin;
	logic [INPUTS-1:0]                lost;
	logic [3:0]                       pen = 4'h0;
	logic [7:0]                       pper = 8'h04;
	logic [3:0]                       divp;
	logic                             los_en = 1'b0;
	logic [LOS_W-1:0]                 los_thr = 16'h0014;
	logic                             wr = 1'b0;
	logic [N2_W-1:0]                  n2 = '0;
	logic [N2_W-1:0]                  n2cal = '0;
	logic [N2_W-1:0]                  n2act;
	logic                             busy;
	logic                             byp = 1'b1;
	logic [3:0]                       ratio = 4'h2;
	logic [3:0]                       step_r;
	logic                             sync_n = 1'b1;
	oddss_delay_cfg_type [GROUPS-1:0] cfg = '0;
	logic [GROUPS-1:0]                grp;
	logic [GROUPS-1:0][DLY_W-1:0]     ld;
	logic [SEL_W-1:0]                 lv [13] = '{SRC_LOW, SRC_LD1, SRC_LD2, SRC_LD_BOTH, SRC_HOLDOVER,
		SRC_DAC_LOCK, SRC_DAC_RAIL, SRC_DAC_LOW, SRC_DAC_HIGH, SRC_SEL0, SRC_SEL1, SRC_READBACK, 5'h1f};
	int                               num_errors = 0;
	int                               n_checks = 0;
	int                               seed = 32'h37e2e26b;
	int                               i, p, k, h, g, r, hi, ch, d, ex;
	int                               w [GROUPS];
	int                               hv [GROUPS];
	int                               old [GROUPS] = '{default: 5};
	longint                           rise [GROUPS];
	longint                           t_edge;
	logic                             prev;

	// ==========================================================
	// Clock, design and far end
	always #20 clk_i = ~clk_i;

	oddss_status_delay i_oddss_status_delay (
		.clk_i(clk_i), .arst_n_i(arst_n_i), .flags_i(flags),
		.loop1_reference_divider_i(divp[0]), .loop1_feedback_divider_i(divp[1]),
		.loop2_reference_divider_i(divp[2]), .loop2_feedback_divider_i(divp[3]),
		.readback_data_i(rb), .active_input_i(act), .status_select_i(sel), .status_o(status),
		.clock_input_i(cin), .signal_loss_detect_enable_i(los_en), .signal_loss_timeout_threshold_i(los_thr),
		.input_signal_lost_flag_o(lost), .loop2_feedback_write_i(wr), .loop2_feedback_divide_value_i(n2),
		.loop2_calibration_divide_value_i(n2cal), .cal_busy_o(busy), .loop2_feedback_active_o(n2act),
		.oscillator_divider_bypass_i(byp), .oscillator_divide_ratio_i(ratio), .delay_step_ratio_o(step_r),
		.sync_n_i(sync_n), .group_cfg_i(cfg), .group_o(grp), .loaded_delay_o(ld));

	oddss_far_end i_oddss_far_end (
		.clk_i(clk_i), .run_i(run), .pulse_en_i(pen), .pulse_period_i(pper),
		.clock_input_o(cin), .divider_pulse_o(divp));

	for (genvar gi = 0; gi < GROUPS; gi++)
	begin : g_rise
		always @(posedge grp[gi]) rise[gi] = $time;
	end

	// ==========================================================
	// Shared tasks and the reference model
	task automatic step(input int n = 1);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %0h seen %0h", name, exp, got);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	function automatic logic lvl(input logic [SEL_W-1:0] c, input oddss_flags_type f, input logic a,
		input logic b);
		case (c)
			SRC_LD1:      return f.ld1;
			SRC_LD2:      return f.ld2;
			SRC_LD_BOTH:  return f.ld1 & f.ld2;
			SRC_HOLDOVER: return f.holdover;
			SRC_DAC_LOCK: return f.dac_locked;
			SRC_DAC_RAIL: return f.dac_rail;
			SRC_DAC_LOW:  return f.dac_low;
			SRC_DAC_HIGH: return f.dac_high;
			SRC_SEL0:     return !a;
			SRC_SEL1:     return a;
			SRC_READBACK: return b;
			default:      return 1'b0;
		endcase
	endfunction

	function automatic int clampw(input int v);
		return (v < 5) ? 5 : (v > 522) ? 522 : v;
	endfunction

	// ==========================================================
	// Watchdog: the tests need about 2500 cycles
	initial
	begin
		#(40 * 10000);
		num_errors++;
		tally_and_finish();
	end

	initial
	begin
		step(7);
		check("reset status", 0, status);
		check("reset busy", 0, busy);
		check("reset step", 1, step_r);
		check("reset groups", 6'h3f, grp);
		for (g = 0; g < GROUPS; g++) check("reset delay", 5, ld[g]);
		step();
		arst_n_i = 1'b1;
		$display("test reset done");

		// Level sources, each pin with its own select
		for (i = 0; i < 40; i++)
		begin
			for (p = 0; p < STATUS_PINS; p++) sel[p] = lv[(i + p) % 13];
			flags = oddss_flags_type'(7'($random(seed)));
			act = 1'($random(seed));
			rb = 1'($random(seed));
			step();
			for (p = 0; p < STATUS_PINS; p++) check("status level", lvl(sel[p], flags, act, rb), status[p]);
		end
		$display("test level sources done");

		// Divider sources, direct and halved, comparison period of 4 cycles
		for (k = 0; k < 4; k++)
			for (h = 0; h < 2; h++)
			begin
				for (p = 0; p < STATUS_PINS; p++) sel[p] = SEL_W'(SRC_R1_DIV + k + 4 * h);
				pen = 4'(1 << k);
				step(8);
				prev = status[0];
				hi = 0;
				ch = 0;
				repeat (64)
				begin
					step();
					hi += status[0];
					ch += (status[0] !== prev);
					prev = status[0];
				end
				check("divider high", h ? 32 : 16, hi);
				check("divider edges", h ? 16 : 32, ch);
			end
		pen = 4'h0;
		$display("test divider sources done");

		// Loss of signal: input 0 running, input 1 stopped
		sel[0] = SRC_LOS0;
		sel[1] = SRC_LOS1;
		run = 2'b01;
		los_en = 1'b1;
		step(60);
		check("lost flags", 2'b10, lost);
		check("lost pins", 2'b10, status[1:0]);
		run = 2'b00;
		step(20);
		check("lost early", 2'b10, lost);
		step(10);
		check("lost late", 2'b11, lost);
		los_en = 1'b0;
		step(2);
		check("lost disabled", 2'b00, lost);
		$display("test signal loss done");

		// Calibration, second round restarted by a write during the run
		for (r = 0; r < 2; r++)
		begin
			n2 = N2_W'($random(seed));
			n2cal = N2_W'($random(seed));
			wr = 1'b1;
			step();
			wr = 1'b0;
			if (r == 1)
			begin
				step(100);
				wr = 1'b1;
				step();
				wr = 1'b0;
			end
			step();
			check("cal busy", 1, busy);
			check("cal value", n2cal, n2act);
			step(CAL_CYCLES - 2);
			check("cal busy end", 1, busy);
			step();
			check("cal done", 0, busy);
			step();
			check("normal value", n2, n2act);
		end
		$display("test calibration done");

		for (i = 0; i < 6; i++)
		begin
			byp = 1'(i % 2);
			ratio = 4'($random(seed));
			step(2);
			check("step ratio", byp ? 4'h1 : ratio, step_r);
		end
		$display("test step ratio done");

		// Synchronisation rounds with one excluded group each
		for (r = 0; r < 2; r++)
		begin
			ex = 5 - r;
			for (g = 0; g < GROUPS; g++)
			begin
				cfg[g].whole = DLY_W'(5 + ($unsigned($random(seed)) % 518));
				cfg[g].half = 1'($random(seed));
				cfg[g].exclude = (g == ex);
				hv[g] = $unsigned($random(seed)) % 2;
			end
			if (r == 0)
			begin
				cfg[0].whole = 10'h005;
				hv[0] = 1;
				cfg[1].whole = 10'h20a;
				hv[1] = 0;
			end
			else
			begin
				cfg[2].whole = 10'h003;
				cfg[3].whole = 10'h258;
			end
			for (g = 0; g < GROUPS; g++) w[g] = (g == ex) ? old[g] : clampw(cfg[g].whole);
			step();
			sync_n = 1'b0;
			step(6);
			for (g = 0; g < GROUPS; g++)
			begin
				check("held group", g == ex, grp[g]);
				check("loaded delay", w[g], ld[g]);
				cfg[g].half = 1'(hv[g]);
				rise[g] = -1;
			end
			step();
			sync_n = 1'b1;
			t_edge = $time + 39;
			step(4);
			for (g = 0; g < GROUPS; g++) cfg[g].whole = DLY_W'(5 + ($unsigned($random(seed)) % 518));
			step(560);
			for (g = 0; g < GROUPS; g++)
			begin
				check("delay kept", w[g], ld[g]);
				if (g == ex)
				begin
					check("excluded", 1, grp[g] === 1'b1 && rise[g] == -1);
				end
				else
				begin
					check("relative delay", 2 * w[g] - hv[g] - 2 * w[0] + hv[0], (rise[g] - rise[0]) / 20);
					d = (rise[g] - t_edge) / 20 - (2 * (6 + w[g]) - hv[g]);
					check("release delay", 1, d >= 0 && d <= 6 && d % 2 == 0);
				end
				old[g] = w[g];
			end
		end
		$display("test sync delay done");
		tally_and_finish();
	end
endmodule
